// ---- boot_image_loader.sv ----
// Purpose: fetch the first boot image from spi flash or over the link
// Assumes: pins are asynchronous to clk_sys; rstn is synchronous, active low
// Notes:   loaded bytes leave through a 4-word fifo on boot_data_*

`timescale 1ns/1ps

module boot_image_loader
    import boot_loader_pkg::*;
#(
    parameter int IMAGE_BYTES = 1024,
    parameter int FIFO_DEPTH  = 4
) (
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        boot_route_pin,
    input  wire logic        xtal_present_pin,
    input  wire logic        lp_osc_pin,
    input  wire logic        boot_spi_data_in_pin,
    output logic             boot_spi_select_pin_n,
    output logic             boot_spi_clock_pin,
    output logic             boot_spi_data_out_pin,
    output logic             boot_spi_pins_oe,
    input  wire logic        boot_link_in_wire0,
    input  wire logic        boot_link_in_wire1,
    output logic             boot_link_out_wire0,
    output logic             boot_link_out_wire1,
    output logic             boot_link_out_oe,
    output logic             boot_link_pulldown_en,
    output logic             chanend0_alloc,
    output logic [31:0]      ack_dest,
    output logic             link_overrun,
    output logic             clk_src_int_osc,
    output logic [31:0]      rtc_count,
    output logic             exec_start,
    output logic [7:0]       boot_data,
    output logic             boot_data_valid,
    input  wire logic        boot_data_ready
);
    localparam int          BCW       = $clog2(IMAGE_BYTES + 1);
    localparam logic [3:0]  HALF_LAST = 4'(SPI_HALF_CYC - 1);
    localparam logic [5:0]  CMD_LAST  = 6'(SPI_CMD_BITS - 1);
    localparam logic [5:0]  BYTE_LAST = 6'(BYTE_BITS - 1);
    localparam logic [3:0]  TOK_LAST  = 4'(TOKEN_BITS - 1);
    localparam logic [3:0]  LBIT_LAST = 4'(LINK_BIT_CYC - 1);
    localparam logic [3:0]  LEN_LAST  = 4'(LINK_EN_DELAY_CYC - 1);
    localparam logic [1:0]  ACKW_LAST = 2'(ACK_WORD_BYTES - 1);
    localparam logic [BCW-1:0] IMG_LAST = BCW'(IMAGE_BYTES - 1);

    // ============================================================
    // pin synchronisers
    logic [5:0] sync1_ff;
    logic [5:0] sync2_ff;
    logic       lnk0_prev_ff;
    logic       lnk1_prev_ff;
    logic       lp_prev_ff;
    logic       route_s;
    logic       xtal_s;
    logic       lp_s;
    logic       miso_s;
    logic       lnk0_s;
    logic       lnk1_s;

    // two flops on every asynchronous pin; stage one feeds stage two only
    // no reset, so the route pin is already settled at the first edge after release
    always_ff @(posedge clk_sys) begin
        sync1_ff <= {boot_link_in_wire1, boot_link_in_wire0, boot_spi_data_in_pin,
                     lp_osc_pin, xtal_present_pin, boot_route_pin};
        sync2_ff <= sync1_ff;
    end

    assign route_s = sync2_ff[0];
    assign xtal_s  = sync2_ff[1];
    assign lp_s    = sync2_ff[2];
    assign miso_s  = sync2_ff[3];
    assign lnk0_s  = sync2_ff[4];
    assign lnk1_s  = sync2_ff[5];

    // previous synchronised levels for edge finding
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            lnk0_prev_ff <= 1'b0;
            lnk1_prev_ff <= 1'b0;
            lp_prev_ff   <= 1'b0;
        end else begin
            lnk0_prev_ff <= lnk0_s;
            lnk1_prev_ff <= lnk1_s;
            lp_prev_ff   <= lp_s;
        end
    end

    // ============================================================
    // oscillator side
    logic [31:0] rtc_ff;

    // no crystal means the silicon oscillator must run the core
    assign clk_src_int_osc = ~xtal_s;

    // counts low-power oscillator rising edges; wraps silently
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rtc_ff <= '0;
        end else if (lp_s && !lp_prev_ff) begin
            rtc_ff <= rtc_ff + 1'b1;
        end
    end
    assign rtc_count = rtc_ff;

    // ============================================================
    // main sequencer and datapath
    state_t          state_ff;
    logic            route_ff;
    logic [3:0]      div_ff;
    logic            sclk_ff;
    logic            cs_n_ff;
    logic            mosi_ff;
    logic [31:0]     cmd_sr_ff;
    logic [5:0]      bit_cnt_ff;
    logic [7:0]      rx_sr_ff;
    logic [BCW-1:0]  byte_cnt_ff;
    logic [7:0]      push_byte_ff;
    logic            push_pend_ff;
    logic            overrun_ff;
    logic [3:0]      wait_ff;
    logic [8:0]      tok_sr_ff;
    logic [3:0]      tok_cnt_ff;
    logic [31:0]     ack_ff;
    logic [1:0]      ackw_cnt_ff;
    logic [8:0]      tx_sr_ff;
    logic [3:0]      tx_cnt_ff;
    logic [3:0]      tx_div_ff;
    logic            out0_ff;
    logic            out1_ff;
    logic            exec_ff;
    logic            spi_tick;
    logic            spi_rise;
    logic            spi_fall;
    logic            spi_run;
    logic            lnk_ev;
    logic            lnk_bit;
    logic            tok_done;
    logic            tok_ctrl;
    logic [7:0]      tok_data;
    logic            push_ok;

    stream_if #(.W(8)) fifo_in ();
    stream_if #(.W(8)) fifo_out ();

    // holding register feeds the fifo; its ready stalls the spi clock
    assign fifo_in.valid = push_pend_ff;
    assign fifo_in.data  = push_byte_ff;
    assign push_ok       = push_pend_ff & fifo_in.ready;

    // spi phase ticks; the clock parks low while a byte waits for room
    assign spi_run  = (state_ff == ST_SPI_CMD) ||
                      ((state_ff == ST_SPI_DATA) && !(push_pend_ff && !sclk_ff && bit_cnt_ff == '0));
    assign spi_tick = spi_run && (div_ff == HALF_LAST);
    assign spi_rise = spi_tick && !sclk_ff;
    assign spi_fall = spi_tick && sclk_ff;

    // a transition on wire1 is a one, on wire0 a zero; both at once is dropped
    assign lnk_ev   = (state_ff inside {ST_LINK_ACKW, ST_LINK_IMG}) &&
                      ((lnk0_s ^ lnk0_prev_ff) ^ (lnk1_s ^ lnk1_prev_ff));
    assign lnk_bit  = lnk1_s ^ lnk1_prev_ff;
    assign tok_done = lnk_ev && (tok_cnt_ff == TOK_LAST);
    assign tok_ctrl = tok_sr_ff[1];
    assign tok_data = {lnk_bit, tok_sr_ff[8:2]};

    // route capture and state sequencing
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state_ff <= ST_IDLE;
            route_ff <= ROUTE_SPI;
            wait_ff  <= '0;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    route_ff <= route_s;
                    state_ff <= (route_s == ROUTE_LINK) ? ST_LINK_WAIT : ST_SPI_CMD;
                end
                ST_SPI_CMD: begin
                    if (spi_fall && bit_cnt_ff == CMD_LAST + 6'd1) begin
                        state_ff <= ST_SPI_DATA;
                    end
                end
                ST_SPI_DATA: begin
                    if (spi_rise && bit_cnt_ff == BYTE_LAST && byte_cnt_ff == IMG_LAST) begin
                        state_ff <= ST_DONE;
                    end
                end
                ST_LINK_WAIT: begin
                    wait_ff <= wait_ff + 1'b1;
                    if (wait_ff == LEN_LAST) begin
                        state_ff <= ST_LINK_ACKW;
                    end
                end
                ST_LINK_ACKW: begin
                    if (tok_done && !tok_ctrl && ackw_cnt_ff == ACKW_LAST) begin
                        state_ff <= ST_LINK_IMG;
                    end
                end
                ST_LINK_IMG: begin
                    if (tok_done && tok_ctrl && tok_data == CTRL_END) begin
                        // a null destination asks for no reply
                        state_ff <= (ack_ff == NULL_CHANEND) ? ST_DONE : ST_LINK_SEND;
                    end
                end
                ST_LINK_SEND: begin
                    if (tx_div_ff == LBIT_LAST && tx_cnt_ff == TOK_LAST) begin
                        state_ff <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state_ff <= ST_DONE;
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // spi clock divider and pin levels
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            div_ff    <= '0;
            sclk_ff   <= 1'b0;
            cs_n_ff   <= 1'b1;
            mosi_ff   <= 1'b0;
            cmd_sr_ff <= '0;
        end else if (state_ff == ST_IDLE && route_s == ROUTE_SPI) begin
            cs_n_ff   <= 1'b0;
            // command goes out msb first as flash parts expect
            cmd_sr_ff <= {FLASH_READ_CMD, FLASH_START_ADDR} << 1;
            mosi_ff   <= FLASH_READ_CMD[7];
        end else if (state_ff == ST_DONE) begin
            sclk_ff <= 1'b0;
            cs_n_ff <= 1'b1;
            mosi_ff <= 1'b0;
        end else if (spi_run) begin
            div_ff <= spi_tick ? '0 : div_ff + 1'b1;
            if (spi_tick) begin
                sclk_ff <= ~sclk_ff;
            end
            // data changes on the falling edge, stable for the next rise
            if (spi_fall) begin
                mosi_ff   <= cmd_sr_ff[31];
                cmd_sr_ff <= cmd_sr_ff << 1;
            end
        end
    end

    // bit and byte counters, lsb-first receive shift
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            bit_cnt_ff  <= '0;
            rx_sr_ff    <= '0;
            byte_cnt_ff <= '0;
        end else if (state_ff == ST_SPI_CMD) begin
            if (spi_fall && bit_cnt_ff == CMD_LAST + 6'd1) begin
                bit_cnt_ff <= '0;
            end else if (spi_rise) begin
                bit_cnt_ff <= bit_cnt_ff + 1'b1;
            end
        end else if (state_ff == ST_SPI_DATA && spi_rise) begin
            rx_sr_ff <= {miso_s, rx_sr_ff[7:1]};
            if (bit_cnt_ff == BYTE_LAST) begin
                bit_cnt_ff  <= '0;
                byte_cnt_ff <= byte_cnt_ff + 1'b1;
            end else begin
                bit_cnt_ff <= bit_cnt_ff + 1'b1;
            end
        end
    end

    // holding register toward the fifo; set wins over the accept
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            push_byte_ff <= '0;
            push_pend_ff <= 1'b0;
            overrun_ff   <= 1'b0;
        end else begin
            if (state_ff == ST_SPI_DATA && spi_rise && bit_cnt_ff == BYTE_LAST) begin
                push_byte_ff <= {miso_s, rx_sr_ff[7:1]};
                push_pend_ff <= 1'b1;
            end else if (state_ff == ST_LINK_IMG && tok_done && !tok_ctrl) begin
                // the link cannot be held off; a byte landing on a full slot overwrites the held one
                if (push_pend_ff && !fifo_in.ready) begin
                    overrun_ff <= 1'b1;
                end
                push_byte_ff <= tok_data;
                push_pend_ff <= 1'b1;
            end else if (push_ok) begin
                push_pend_ff <= 1'b0;
            end
        end
    end

    // link token assembly and acknowledgement destination word
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            tok_sr_ff   <= '0;
            tok_cnt_ff  <= '0;
            ack_ff      <= '0;
            ackw_cnt_ff <= '0;
        end else if (lnk_ev) begin
            tok_sr_ff  <= {lnk_bit, tok_sr_ff[8:1]};
            tok_cnt_ff <= tok_done ? '0 : tok_cnt_ff + 1'b1;
            if (tok_done && !tok_ctrl && state_ff == ST_LINK_ACKW) begin
                ack_ff      <= {ack_ff[23:0], tok_data};
                ackw_cnt_ff <= ackw_cnt_ff + 1'b1;
            end
        end
    end

    // end token transmit by wire transitions, one bit per link bit time
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            tx_sr_ff  <= '0;
            tx_cnt_ff <= '0;
            tx_div_ff <= '0;
            out0_ff   <= 1'b0;
            out1_ff   <= 1'b0;
        end else if (state_ff == ST_LINK_IMG) begin
            tx_sr_ff  <= {CTRL_END, 1'b1};
            tx_cnt_ff <= '0;
            tx_div_ff <= '0;
        end else if (state_ff == ST_LINK_SEND) begin
            tx_div_ff <= (tx_div_ff == LBIT_LAST) ? '0 : tx_div_ff + 1'b1;
            if (tx_div_ff == '0) begin
                out0_ff  <= out0_ff ^ ~tx_sr_ff[0];
                out1_ff  <= out1_ff ^ tx_sr_ff[0];
                tx_sr_ff <= tx_sr_ff >> 1;
            end
            if (tx_div_ff == LBIT_LAST) begin
                tx_cnt_ff <= tx_cnt_ff + 1'b1;
            end
        end
    end

    // execution starts only after everything above has finished
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            exec_ff <= 1'b0;
        end else if (state_ff == ST_DONE && !push_pend_ff) begin
            exec_ff <= 1'b1;
        end
    end

    // ============================================================
    // output fifo
    stream_fifo #(
        .W (8),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .wr      (fifo_in),
        .rd      (fifo_out)
    );

    assign boot_data       = fifo_out.data;
    assign boot_data_valid = fifo_out.valid;
    assign fifo_out.ready  = boot_data_ready;

    // ============================================================
    // pins; the spi pin set is hard-wired here and nowhere configurable
    assign boot_spi_pins_oe      = (state_ff inside {ST_SPI_CMD, ST_SPI_DATA}) || !cs_n_ff;
    assign boot_spi_clock_pin    = sclk_ff;
    assign boot_spi_select_pin_n = cs_n_ff;
    assign boot_spi_data_out_pin = mosi_ff;

    // link enabled from the end of the delay on, and still in ST_DONE after channel end zero is freed
    assign boot_link_out_oe      = (route_ff == ROUTE_LINK) &&
                                   (state_ff inside {ST_LINK_ACKW, ST_LINK_IMG, ST_LINK_SEND, ST_DONE});
    assign boot_link_pulldown_en = ~boot_link_out_oe;
    assign boot_link_out_wire0   = out0_ff;
    assign boot_link_out_wire1   = out1_ff;
    assign chanend0_alloc        = (state_ff inside {ST_LINK_ACKW, ST_LINK_IMG, ST_LINK_SEND});
    assign ack_dest              = ack_ff;
    assign link_overrun          = overrun_ff;
    assign exec_start            = exec_ff;

endmodule : boot_image_loader

// ---- boot_loader_pkg.sv ----
// Purpose: shared constants and types for the boot image loader
// Assumes: system clock of 25 MHz
// Notes:   all timing counts derive from the named times below

// ============================================================
// package
package boot_loader_pkg;

    // clocking and spi timing
    localparam int SYS_CLK_HZ      = 25_000_000;
    localparam int SPI_REF_CORE_HZ = 400_000_000;
    localparam int SPI_SCLK_HZ     = 2_500_000;
    localparam int SPI_HALF_CYC    = SYS_CLK_HZ / (2 * SPI_SCLK_HZ);

    // flash read command and start address
    localparam logic [7:0]  FLASH_READ_CMD   = 8'h03;
    localparam logic [23:0] FLASH_START_ADDR = 24'h000000;
    localparam int          SPI_CMD_BITS     = 32;
    localparam int          BYTE_BITS        = 8;

    // link timing: enable delay is a least time, bit spacing a longest
    localparam int LINK_EN_DELAY_NS  = 200;
    localparam int LINK_EN_DELAY_CYC = (LINK_EN_DELAY_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int LINK_BIT_NS       = 320;
    localparam int LINK_BIT_CYC      = (LINK_BIT_NS * (SYS_CLK_HZ / 1_000_000)) / 1000;

    // link tokens: one control flag then eight data bits
    localparam int          TOKEN_BITS     = 9;
    localparam logic [7:0]  CTRL_END       = 8'h01;
    localparam logic [31:0] NULL_CHANEND   = 32'h0000FF02;
    localparam int          ACK_WORD_BYTES = 4;

    // boot route encoding on the selection pin
    localparam logic ROUTE_SPI  = 1'b0;
    localparam logic ROUTE_LINK = 1'b1;

    typedef enum logic [7:0] {
        ST_IDLE      = 8'b0000_0001,
        ST_SPI_CMD   = 8'b0000_0010,
        ST_SPI_DATA  = 8'b0000_0100,
        ST_LINK_WAIT = 8'b0000_1000,
        ST_LINK_ACKW = 8'b0001_0000,
        ST_LINK_IMG  = 8'b0010_0000,
        ST_LINK_SEND = 8'b0100_0000,
        ST_DONE      = 8'b1000_0000
    } state_t;

endpackage : boot_loader_pkg

// ---- stream_if.sv ----
// Purpose: valid/ready byte stream between loader modules
// Assumes: single clock domain
// Notes:   data is held by the source until accepted, except a link byte that overwrites a full slot

`timescale 1ns/1ps

// ============================================================
// interface
interface stream_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : stream_if

// ---- stream_fifo.sv ----
// Purpose: small synchronous fifo in the boot data path
// Assumes: depth is a power of two
// Notes:   no read-through; a word becomes visible the cycle after write

`timescale 1ns/1ps

// ============================================================
// fifo
module stream_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    input  wire logic clk_sys,
    input  wire logic rstn,
    stream_if.snk     wr,
    stream_if.src     rd
);
    localparam int AW = $clog2(D);

    logic [W-1:0]  mem [D];
    logic [AW-1:0] wptr_ff;
    logic [AW-1:0] rptr_ff;
    logic [AW:0]   count_ff;
    logic          do_wr;
    logic          do_rd;

    // honest full and empty from the occupancy count
    assign wr.ready = (count_ff != (AW+1)'(D));
    assign rd.valid = (count_ff != '0);
    assign rd.data  = mem[rptr_ff];
    assign do_wr    = wr.valid & wr.ready;
    assign do_rd    = rd.valid & rd.ready;

    // storage carries no reset, only pointers and count do
    always_ff @(posedge clk_sys) begin
        if (do_wr) begin
            mem[wptr_ff] <= wr.data;
        end
    end

    // pointers and occupancy
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            wptr_ff  <= '0;
            rptr_ff  <= '0;
            count_ff <= '0;
        end else begin
            if (do_wr) begin
                wptr_ff <= wptr_ff + 1'b1;
            end
            if (do_rd) begin
                rptr_ff <= rptr_ff + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count_ff <= count_ff + 1'b1;
            end else if (do_rd && !do_wr) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end

endmodule : stream_fifo

// ---- boot_image_loader_checker.sv ----
// Purpose: port assertions for boot_image_loader
// Assumes: one clk_sys domain, rstn synchronous active low
// Notes:   bound to the loader at the foot of this file
`timescale 1ns/1ps
// ============================================================
// checker
module boot_image_loader_checker (
    input wire logic        clk_sys,
    input wire logic        rstn,
    input wire logic        xtal_present_pin,
    input wire logic        boot_spi_select_pin_n,
    input wire logic        boot_spi_clock_pin,
    input wire logic        boot_spi_pins_oe,
    input wire logic        boot_link_out_wire0,
    input wire logic        boot_link_out_wire1,
    input wire logic        boot_link_out_oe,
    input wire logic        boot_link_pulldown_en,
    input wire logic        chanend0_alloc,
    input wire logic        clk_src_int_osc,
    input wire logic [31:0] rtc_count,
    input wire logic        exec_start
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // spi side: pins driven while selected, clock idles low, high half is 5 cycles
    chk_spi_pins_on: assert property (!boot_spi_select_pin_n |-> boot_spi_pins_oe)
        else $error("spi pins not enabled while selected");
    chk_sclk_high_half: assert property ($fell(boot_spi_clock_pin) && !boot_spi_select_pin_n
        |-> $past(boot_spi_clock_pin, 5) && !$past(boot_spi_clock_pin, 6)) else $error("sclk high half not 5");
    chk_sclk_idle_low: assert property (boot_spi_select_pin_n |-> !boot_spi_clock_pin)
        else $error("sclk not low while deselected");
    chk_route_exclusive: assert property (boot_link_out_oe |-> boot_spi_select_pin_n && !boot_spi_pins_oe)
        else $error("spi active on link route");
    // link side: enable drops pulls and starts with both wires low
    chk_pulldown_off: assert property (boot_link_pulldown_en == !boot_link_out_oe)
        else $error("pulldown not inverse of link enable");
    chk_link_idle_low: assert property ($rose(boot_link_out_oe) |-> !boot_link_out_wire0 && !boot_link_out_wire1)
        else $error("link wires not low at enable");
    chk_chanend_held: assert property (chanend0_alloc |-> boot_link_out_oe && !exec_start)
        else $error("channel end held outside link load");
    chk_exec_stays: assert property (exec_start |=> exec_start)
        else $error("exec_start dropped");
    // clock sources
    chk_osc_select: assert property ($stable(xtal_present_pin) [*4] |-> clk_src_int_osc == !xtal_present_pin)
        else $error("clock source does not follow crystal");
    chk_rtc_step: assert property (rtc_count != $past(rtc_count) |-> rtc_count == $past(rtc_count) + 32'h1)
        else $error("rtc stepped by more than one");
endmodule : boot_image_loader_checker

bind boot_image_loader boot_image_loader_checker chk (.*);

// ---- flash_model.sv ----
// Purpose: behavioural serial flash answering the boot read
// Assumes: mode 0, command then data on one select
// Notes:   image is fixed by the bench before the fetch
`timescale 1ns/1ps
// ============================================================
// flash
module flash_model (
    input  wire logic        boot_spi_select_pin_n,
    input  wire logic        boot_spi_clock_pin,
    input  wire logic        boot_spi_data_out_pin,
    input  wire logic [31:0] image,
    output logic             boot_spi_data_in_pin,
    output logic [31:0]      cmd
);
    int   rises = 0;
    logic drv   = 1'b0;
    // released line is not held: show the inverse of the last bit
    assign boot_spi_data_in_pin = boot_spi_select_pin_n ? ~drv : drv;
    always @(negedge boot_spi_select_pin_n) rises = 0;
    // capture on the rising edge, shift out on the falling edge
    always @(posedge boot_spi_clock_pin) begin
        if (!boot_spi_select_pin_n && rises < 32) cmd = {cmd[30:0], boot_spi_data_out_pin};
        rises++;
    end
    // stored bytes already reversed, so image bit k leaves k-th
    always @(negedge boot_spi_clock_pin) begin
        if (!boot_spi_select_pin_n && rises >= 32) drv = image[(rises - 32) % 32];
    end
endmodule : flash_model

// ---- boot_image_loader_test.sv ----
// Purpose: self-checking bench for both boot routes
// Assumes: clk_sys 40 ns, link bits 320 ns apart
// Notes:   inputs change at the falling edge
`timescale 1ns/1ps
// ============================================================
// bench
module boot_image_loader_test;
    import boot_loader_pkg::*;
    logic        clk_sys, rstn, boot_route_pin, xtal_present_pin, lp_osc_pin;
    logic        boot_link_in_wire0, boot_link_in_wire1, boot_data_ready, boot_spi_data_in_pin;
    logic        boot_spi_select_pin_n, boot_spi_clock_pin, boot_spi_data_out_pin, boot_spi_pins_oe;
    logic        boot_link_out_wire0, boot_link_out_wire1, boot_link_out_oe, boot_link_pulldown_en;
    logic        chanend0_alloc, link_overrun, clk_src_int_osc, exec_start, boot_data_valid;
    logic [31:0] ack_dest, rtc_count, image, cmd, ack;
    logic [7:0]  boot_data;
    logic [7:0]  q[$];
    logic [15:0] seed = 16'h310C;
    logic [15:0] rseed = 16'h310C;
    logic [8:0]  rep;
    logic [1:0]  prev = 2'h0;
    int          fail_count = 0, samples_checked = 0, nrep;

    boot_image_loader #(.IMAGE_BYTES(4)) dut (.*);
    flash_model flash (.*);

    function automatic logic [15:0] lfsr(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    // token as sent on the wire: flag first, then data lsb first
    function automatic logic [8:0] tok_bits(logic ctl, logic [7:0] d);
        return {ctl, d[0], d[1], d[2], d[3], d[4], d[5], d[6], d[7]};
    endfunction : tok_bits
    task automatic check(logic [31:0] got, logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask : check
    task automatic cyc(int n);
        repeat (n) @(negedge clk_sys);
    endtask : cyc
    task automatic rand_word(output logic [31:0] w);
        seed = lfsr(seed);
        w[15:0] = seed;
        seed = lfsr(seed);
        w[31:16] = seed;
    endtask : rand_word
    task automatic do_reset(logic r);
        rstn = 1'b0;
        boot_route_pin = r;
        {boot_link_in_wire0, boot_link_in_wire1} = 2'h0;
        cyc(6);
        q = {};
        nrep = 0;
        rep = 9'h0;
        rstn = 1'b1;
    endtask : do_reset
    task automatic wait_exec;
        for (int i = 0; i < 4000 && exec_start !== 1'b1; i++) cyc(1);
    endtask : wait_exec
    // one wire transition per bit: wire1 for a one, wire0 for a zero
    task automatic send_tok(logic [8:0] b);
        for (int i = 8; i >= 0; i--) begin
            if (b[i]) boot_link_in_wire1 = ~boot_link_in_wire1;
            else boot_link_in_wire0 = ~boot_link_in_wire0;
            cyc(8);
        end
    endtask : send_tok
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // consumer stalls at random so bytes wait in the fifo
    always @(negedge clk_sys) begin
        rseed = lfsr(rseed);
        boot_data_ready <= rseed[0] | rseed[1];
    end
    // collect accepted bytes and decode the reply token on the out wires
    always @(posedge clk_sys) begin
        if (rstn && boot_data_valid === 1'b1 && boot_data_ready === 1'b1) q.push_back(boot_data);
        if (rstn && {boot_link_out_wire1, boot_link_out_wire0} != prev) begin
            rep = {rep[7:0], boot_link_out_wire1 != prev[1]};
            nrep++;
        end
        prev = {boot_link_out_wire1, boot_link_out_wire0};
    end
    // run is about two thousand cycles; some fifteen times that means a hang
    initial begin
        cyc(30000);
        fail_count++;
        give_verdict;
    end

    initial begin
        {rstn, boot_route_pin, xtal_present_pin, lp_osc_pin, boot_link_in_wire0, boot_link_in_wire1} = 6'h0;
        boot_data_ready = 1'b0;
        rand_word(image);
        image[7:0] = 8'h01; // lone low bit exposes a reversed byte
        do_reset(ROUTE_SPI);
        xtal_present_pin = 1'b1;
        cyc(4);
        check(clk_src_int_osc, 0);
        xtal_present_pin = 1'b0;
        cyc(4);
        check(clk_src_int_osc, 1);
        repeat (5) begin
            lp_osc_pin = 1'b1;
            cyc(3);
            lp_osc_pin = 1'b0;
            cyc(3);
        end
        check(rtc_count, 5);
        wait_exec;
        cyc(40);
        check(cmd, {FLASH_READ_CMD, FLASH_START_ADDR});
        check(q.size(), 4);
        foreach (q[i]) check(q[i], image[8*i+:8]);
        check({boot_spi_pins_oe, boot_link_out_oe, exec_start}, 3'h1);
        $display("test spi route done");
        // link route: answered ack, then the null channel end
        for (int k = 0; k < 2; k++) begin
            rand_word(ack);
            rand_word(image);
            if (k == 1) ack = NULL_CHANEND;
            do_reset(ROUTE_LINK);
            cyc(2);
            check(boot_link_out_oe, 0);
            cyc(8);
            check({boot_link_out_oe, boot_link_pulldown_en, boot_link_out_wire1, boot_link_out_wire0}, 4'h8);
            for (int i = 3; i >= 0; i--) send_tok(tok_bits(1'b0, ack[8*i+:8]));
            check(chanend0_alloc, 1);
            for (int i = 0; i < 2; i++) send_tok(tok_bits(1'b0, image[8*i+:8]));
            send_tok(tok_bits(1'b1, CTRL_END));
            wait_exec;
            cyc(120);
            check(ack_dest, ack);
            check(q.size(), 2);
            foreach (q[i]) check(q[i], image[8*i+:8]);
            check(nrep, k ? 0 : 9);
            check(rep, k ? 9'h0 : tok_bits(1'b1, CTRL_END));
            check({chanend0_alloc, link_overrun, exec_start}, 3'h1);
            $display("test link route %0d done", k);
        end
        give_verdict;
    end
endmodule : boot_image_loader_test
